// [shared/sox_pkg.sv]
// Purpose: Shared constants for the static output / serial master / mask block
// Assumes: 250 MHz system clock, active-low asynchronous reset
// Notes:   Times are kept in their own unit; cycle counts derive from them
// Functional notes
// - Eight static bits hold host value, readable, untouched while measuring.
// - Serial transfer length 1 to 32 bits, 8 after reset.
// - Mode 0..3 picks clock edge (bit 0) and phase (bit 1).
// - Serial clock period never below configured minimum, at least 160 us.
// - Route option puts serial lines on static (0) or pattern (1) bits.
// - Select on bit 5, clock bit 6, data out bit 7, data in pin 0.
// - Configuration leaves select high and clock at its idle level.
// - Serial master works only in the low speed operating mode.
// - Read shifts optional word out and returns word sampled on input.
// - Write shifts supplied word out with length, mode and period set.
// - End argument 0 keeps select low, 1 raises it after transfer.
// - Each set mask bit inverts that data bit; mask resets to zero.
// - Mask applies to memory writes and reads in every mode.
// - Operating mode 0 is low speed (default); 1 and 2 high speed.
package sox_pkg;

    localparam int          CLK_FREQ_MHZ       = 250;
    localparam int          T_SER_MIN_PERIOD_US = 160;
    localparam int          SER_MIN_HALF_CYC   =
        (T_SER_MIN_PERIOD_US * CLK_FREQ_MHZ + 1) / 2;
    localparam int          SER_MAX_BITS       = 32;
    localparam logic [5:0]  SER_LEN_RESET      = 6'h08;
    localparam logic [1:0]  SER_MODE_RESET     = 2'h0;
    localparam logic        SER_ROUTE_RESET    = 1'h0;
    localparam logic [7:0]  STATIC_RESET       = 8'h00;
    localparam int          SER_CS_BIT         = 5;
    localparam int          SER_CLK_BIT        = 6;
    localparam int          SER_DOUT_BIT       = 7;
    localparam int          SER_MODE_EDGE_BIT  = 0;
    localparam int          SER_MODE_PHASE_BIT = 1;
    localparam logic [2:0]  OPMODE_LOW_SPEED   = 3'h0;
    localparam logic [2:0]  OPMODE_HS_CAPTURE  = 3'h1;
    localparam logic [2:0]  OPMODE_HS_STIMULUS = 3'h2;
    localparam int          MASK_WIDTH         = 24;

    typedef enum logic [1:0] {
        SOX_IDLE,
        SOX_SHIFT,
        SOX_DONE
    } sox_state_t;

endpackage

// [core/sox_pair_buf.sv]
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock domain
// Notes:   in_ready_out is low only while both entries are full
`timescale 1ns/1ps
module sox_pair_buf #(
    parameter int W = 32
) (
    input  wire logic         clk_sys_in,
    input  wire logic         resetn_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    logic [W-1:0] mem_q [2];
    logic         wr_ptr_q;
    logic         rd_ptr_q;
    logic [1:0]   cnt_q;
    wire          push;
    wire          pop;

    assign in_ready_out  = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out  = mem_q[rd_ptr_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr_q <= 1'h0;
            rd_ptr_q <= 1'h0;
            cnt_q    <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_ptr_q] <= in_data_in;
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            if (push && !pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop && !push)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule

// [core/sox_serial_core.sv]
// Purpose: Static output bits, software serial master and data inversion mask
// Assumes: Host strobes are on clk_sys_in; serial input pin is asynchronous
// Notes:   Serial lines replace bits 5..7 once configured in low speed mode
`timescale 1ns/1ps
module sox_serial_core
    import sox_pkg::*;
#(
    parameter int MIN_HALF_CYC = SER_MIN_HALF_CYC,
    parameter int DW           = MASK_WIDTH
) (
    input  wire logic          clk_sys_in,
    input  wire logic          resetn_in,
    input  wire logic [2:0]    opmode_in,
    input  wire logic          meas_active_in,
    input  wire logic          static_wr_in,
    input  wire logic [7:0]    static_data_in,
    output logic [7:0]         static_readback_out,
    output logic [7:0]         static_output_bits_out,
    input  wire logic [7:0]    pattern_bits_in,
    output logic [7:0]         pattern_bit_outputs_out,
    input  wire logic          serial_config_wr_in,
    input  wire logic [5:0]    cfg_len_in,
    input  wire logic [1:0]    cfg_mode_in,
    input  wire logic [15:0]   cfg_period_us_in,
    input  wire logic          cfg_route_in,
    input  wire logic          xfer_start_in,
    input  wire logic          xfer_read_in,
    input  wire logic [31:0]   xfer_data_in,
    input  wire logic          xfer_cs_end_in,
    output logic               xfer_ready_out,
    output logic               busy_out,
    input  wire logic          serial_input_pin_in,
    output logic               rd_valid_out,
    input  wire logic          rd_ready_in,
    output logic [31:0]        rd_data_out,
    input  wire logic          mask_wr_in,
    input  wire logic [DW-1:0] mask_data_in,
    output logic [DW-1:0]      mask_readback_out,
    input  wire logic [DW-1:0] mem_wr_data_in,
    output logic [DW-1:0]      mem_wr_data_out,
    input  wire logic [DW-1:0] mem_rd_data_in,
    output logic [DW-1:0]      io_data_out
);
    sox_state_t   st_q;
    logic [7:0]   static_q;
    logic [5:0]   len_q;
    logic [1:0]   mode_q;
    logic [31:0]  half_q;
    logic         route_q;
    logic         spi_en_q;
    logic [31:0]  tx_q;
    logic [31:0]  rx_q;
    logic         dout_q;
    logic         sclk_q;
    logic         cs_q;
    logic [31:0]  cnt_q;
    logic [6:0]   edges_q;
    logic         read_q;
    logic         end_q;
    logic         sin_m_q;
    logic         sin_s_q;
    logic [7:0]   static_pins_q;
    logic [7:0]   pattern_pins_q;
    logic [DW-1:0] mask_q;
    logic [DW-1:0] mem_wr_q;
    logic [DW-1:0] io_q;
    logic [31:0]  since_q;

    wire          low_speed;
    wire          buf_in_ready;
    wire          cfg_take;
    wire          start_take;
    wire          tick;
    wire          last_done;
    wire          lead_edge;
    wire          do_sample;
    wire          do_shift;
    wire          cpol;
    wire          cpha;
    wire          ser_on;
    wire          push;
    wire [5:0]    cfg_len;
    wire [31:0]   cfg_half;
    wire [31:0]   new_half;
    wire [31:0]   tx_load;
    wire [2:0]    ser_lines;
    wire [7:0]    static_mux;
    wire [7:0]    pattern_mux;

    assign low_speed  = (opmode_in == OPMODE_LOW_SPEED);
    assign cpol       = mode_q[SER_MODE_EDGE_BIT];
    assign cpha       = mode_q[SER_MODE_PHASE_BIT];
    assign cfg_take   = serial_config_wr_in && low_speed && (st_q == SOX_IDLE);
    assign xfer_ready_out = (st_q == SOX_IDLE) && low_speed && spi_en_q
                            && buf_in_ready;
    assign start_take = xfer_start_in && xfer_ready_out;
    assign busy_out   = (st_q != SOX_IDLE);
    assign cfg_len    = (cfg_len_in == 6'h00) ? 6'h01 :
                        (cfg_len_in > 6'(SER_MAX_BITS)) ? 6'(SER_MAX_BITS) :
                        cfg_len_in;
    assign cfg_half   = (32'(cfg_period_us_in) * 32'(CLK_FREQ_MHZ)
                         + 32'h1) >> 1;
    assign new_half   = (cfg_half < 32'(MIN_HALF_CYC)) ? 32'(MIN_HALF_CYC)
                        : cfg_half;
    assign tx_load    = xfer_data_in << (6'(SER_MAX_BITS) - len_q);
    assign tick       = (st_q == SOX_SHIFT) && (cnt_q == half_q - 32'h1);
    assign last_done  = (edges_q == {len_q, 1'b0});
    assign lead_edge  = ~edges_q[0];
    assign do_sample  = tick && !last_done && (lead_edge ^ cpha);
    assign do_shift   = tick && !last_done && !(lead_edge ^ cpha);
    assign push       = (st_q == SOX_DONE) && read_q;
    assign ser_on     = spi_en_q && low_speed;
    assign ser_lines  = {dout_q, sclk_q, cs_q};
    assign static_mux = (ser_on && !route_q) ?
                        {ser_lines, static_q[4:0]} : static_q;
    assign pattern_mux = (ser_on && route_q) ?
                        {ser_lines, pattern_bits_in[4:0]} : pattern_bits_in;

    assign static_readback_out     = static_q;
    assign static_output_bits_out  = static_pins_q;
    assign pattern_bit_outputs_out = pattern_pins_q;
    assign mask_readback_out       = mask_q;
    assign mem_wr_data_out         = mem_wr_q;
    assign io_data_out             = io_q;

    // Input pin synchroniser
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sin_m_q <= 1'b0;
            sin_s_q <= 1'b0;
        end
        else
        begin
            sin_m_q <= serial_input_pin_in;
            sin_s_q <= sin_m_q;
        end
    end

    // Static bits, pins and mask
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            static_q       <= STATIC_RESET;
            static_pins_q  <= STATIC_RESET;
            pattern_pins_q <= 8'h00;
            mask_q         <= '0;
            mem_wr_q       <= '0;
            io_q           <= '0;
        end
        else
        begin
            if (static_wr_in && !meas_active_in)
                static_q <= static_data_in;
            static_pins_q  <= static_mux;
            pattern_pins_q <= pattern_mux;
            if (mask_wr_in)
                mask_q <= mask_data_in;
            mem_wr_q <= mem_wr_data_in ^ mask_q;
            io_q     <= mem_rd_data_in ^ mask_q;
        end
    end

    // Configuration
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            len_q    <= SER_LEN_RESET;
            mode_q   <= SER_MODE_RESET;
            half_q   <= 32'(SER_MIN_HALF_CYC);
            route_q  <= SER_ROUTE_RESET;
            spi_en_q <= 1'b0;
        end
        else if (cfg_take)
        begin
            len_q    <= cfg_len;
            mode_q   <= cfg_mode_in;
            half_q   <= new_half;
            route_q  <= cfg_route_in;
            spi_en_q <= 1'b1;
        end
    end

    // Serial sequencer
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_q    <= SOX_IDLE;
            tx_q    <= 32'h0;
            rx_q    <= 32'h0;
            dout_q  <= 1'b0;
            sclk_q  <= 1'b0;
            cs_q    <= 1'b1;
            cnt_q   <= 32'h0;
            edges_q <= 7'h00;
            read_q  <= 1'b0;
            end_q   <= 1'b1;
        end
        else
        begin
            unique case (st_q)
                SOX_IDLE:
                begin
                    if (cfg_take)
                    begin
                        cs_q   <= 1'b1;
                        sclk_q <= cfg_mode_in[SER_MODE_EDGE_BIT];
                    end
                    else if (start_take)
                    begin
                        cs_q    <= 1'b0;
                        cnt_q   <= 32'h0;
                        edges_q <= 7'h00;
                        rx_q    <= 32'h0;
                        read_q  <= xfer_read_in;
                        end_q   <= xfer_cs_end_in;
                        st_q    <= SOX_SHIFT;
                        if (!cpha)
                        begin
                            dout_q <= tx_load[31];
                            tx_q   <= tx_load << 1;
                        end
                        else
                            tx_q <= tx_load;
                    end
                end
                SOX_SHIFT:
                begin
                    cnt_q <= tick ? 32'h0 : cnt_q + 32'h1;
                    if (tick && last_done)
                    begin
                        cs_q <= end_q;
                        st_q <= SOX_DONE;
                    end
                    else if (tick)
                    begin
                        sclk_q  <= ~sclk_q;
                        edges_q <= edges_q + 7'h01;
                    end
                    if (do_sample)
                        rx_q <= {rx_q[30:0], sin_s_q};
                    if (do_shift)
                    begin
                        dout_q <= tx_q[31];
                        tx_q   <= tx_q << 1;
                    end
                end
                SOX_DONE:
                    st_q <= SOX_IDLE;
            endcase
        end
    end

    sox_pair_buf #(
        .W (32)
    ) u_rd_buf (
        .clk_sys_in    (clk_sys_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (push),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (rx_q),
        .out_valid_out (rd_valid_out),
        .out_ready_in  (rd_ready_in),
        .out_data_out  (rd_data_out)
    );

    // Cycles since the last serial clock change, for checking only
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            since_q <= 32'h0;
        else if (sclk_q != $past(sclk_q))
            since_q <= 32'h1;
        else if (since_q != 32'hFFFFFFFF)
            since_q <= since_q + 32'h1;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    sequence s_start;
        start_take;
    endsequence
    sequence s_cs_low_idle_clk;
        !cs_q && (sclk_q == cpol);
    endsequence

    property p_static_hold;
        meas_active_in && static_wr_in |=> $stable(static_q);
    endproperty
    a_static_hold: assert property (p_static_hold)
        else $error("static bits changed during measurement");

    property p_len_range;
        (len_q >= 6'h01) && (len_q <= 6'h20);
    endproperty
    a_len_range: assert property (p_len_range)
        else $error("serial length outside 1..32");

    property p_min_period;
        (st_q == SOX_SHIFT) && (sclk_q != $past(sclk_q))
            && (edges_q > 7'h01) |-> (since_q >= half_q);
    endproperty
    a_min_period: assert property (p_min_period)
        else $error("serial clock half period too short");

    property p_route_pattern;
        ser_on && route_q |=> pattern_pins_q[SER_CLK_BIT] == $past(sclk_q)
            && pattern_pins_q[SER_CS_BIT] == $past(cs_q);
    endproperty
    a_route_pattern: assert property (p_route_pattern)
        else $error("serial lines missing on pattern bits");

    property p_route_static;
        ser_on && !route_q |=> static_pins_q[SER_DOUT_BIT] == $past(dout_q);
    endproperty
    a_route_static: assert property (p_route_static)
        else $error("serial data missing on static bit 7");

    property p_cfg_idle;
        cfg_take |=> cs_q && (sclk_q == cpol);
    endproperty
    a_cfg_idle: assert property (p_cfg_idle)
        else $error("configuration did not idle the bus");

    property p_mode_gate;
        !low_speed |-> !xfer_ready_out && !cfg_take;
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("serial master offered outside low speed");

    property p_cs_first;
        s_start |=> s_cs_low_idle_clk [*2];
    endproperty
    a_cs_first: assert property (p_cs_first)
        else $error("select not low before first clock edge");

    property p_cs_end;
        (st_q == SOX_SHIFT) && tick && last_done |=> cs_q == end_q
            ##1 (st_q == SOX_IDLE);
    endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("select state wrong at end of transfer");

    property p_read_push;
        (st_q == SOX_DONE) && read_q |=> rd_valid_out;
    endproperty
    a_read_push: assert property (p_read_push)
        else $error("read result not queued");

    property p_mask;
        ##1 mem_wr_q == ($past(mem_wr_data_in) ^ $past(mask_q))
            && io_q == ($past(mem_rd_data_in) ^ $past(mask_q));
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask not applied to memory data");
endmodule

// [tb/sox_spi_peer.sv]
// Purpose: Serial peripheral model on the load board side of the master
// Assumes: Select, clock and data lines come from registered pins
// Notes:   Reloads its word at select fall or on a load pulse
`timescale 1ns/1ps
module sox_spi_peer (
    input  wire logic        sel_in,
    input  wire logic        sclk_in,
    input  wire logic        dout_in,
    input  wire logic        load_in,
    input  wire logic [1:0]  mode_in,
    input  wire logic [5:0]  len_in,
    input  wire logic [31:0] tx_in,
    output logic             din_out,
    output logic [31:0]      rx_out
);
    logic [31:0] sh;
    logic        lead;

    initial
    begin
        sh      = 32'h0;
        rx_out  = 32'h0;
        din_out = 1'b0;
    end

    // Word left aligned so that its top bit leaves first
    always @(negedge sel_in or posedge load_in)
    begin
        sh     = tx_in << (32 - len_in);
        rx_out = 32'h0;
        if (!mode_in[1])
        begin
            din_out = sh[31];
            sh      = sh << 1;
        end
    end

    // Released line shows the inverse of its last bit
    always @(posedge sel_in)
        din_out = ~din_out;

    // Sample on one edge, change on the other, per phase
    always @(sclk_in)
    begin
        lead = (sclk_in != mode_in[0]);
        if (!sel_in && (lead ^ mode_in[1]))
            rx_out = {rx_out[30:0], dout_in};
        else if (!sel_in)
        begin
            din_out = sh[31];
            sh      = sh << 1;
        end
    end
endmodule

// [tb/tb_sox_serial_core.sv]
// Purpose: Self-checking bench for static bits, serial master and mask
// Assumes: Half period shortened to 8 cycles, period input at 0 except one 1 us case
// Notes:   Serial clock period is 16 cycles, 64 ns (250 cycles for the 1 us case); read results stall
`timescale 1ns/1ps
module tb_sox_serial_core
    import sox_pkg::*;
;
    localparam int H = 8;
    logic        clk, rstn, meas, swr, cwr, rt, xs, xrd, xend, rr, mwr, go;
    logic        din, xrdy, busy, rv;
    logic [2:0]  opm;
    logic [7:0]  sd, sb, sp, pin, po, sv;
    logic [5:0]  cl, el;
    logic [1:0]  cm;
    logic [15:0] per;
    logic [31:0] xd, rd, ptx, prx;
    logic [23:0] md, mb, mwi, mwo, mri, mio;
    logic [31:0] q[$];
    int          n_fail, num_checks;
    int          lens[5] = '{0, 1, 8, 32, 40};
    wire         sel_w  = rt ? po[SER_CS_BIT] : sp[SER_CS_BIT];
    wire         sclk_w = rt ? po[SER_CLK_BIT] : sp[SER_CLK_BIT];
    wire         dout_w = rt ? po[SER_DOUT_BIT] : sp[SER_DOUT_BIT];

    sox_serial_core #(.MIN_HALF_CYC(H), .DW(MASK_WIDTH)) dut (
        .clk_sys_in(clk), .resetn_in(rstn), .opmode_in(opm),
        .meas_active_in(meas), .static_wr_in(swr), .static_data_in(sd),
        .static_readback_out(sb), .static_output_bits_out(sp),
        .pattern_bits_in(pin), .pattern_bit_outputs_out(po),
        .serial_config_wr_in(cwr), .cfg_len_in(cl), .cfg_mode_in(cm),
        .cfg_period_us_in(per), .cfg_route_in(rt),
        .xfer_start_in(xs), .xfer_read_in(xrd), .xfer_data_in(xd),
        .xfer_cs_end_in(xend), .xfer_ready_out(xrdy), .busy_out(busy),
        .serial_input_pin_in(din), .rd_valid_out(rv), .rd_ready_in(rr),
        .rd_data_out(rd), .mask_wr_in(mwr), .mask_data_in(md),
        .mask_readback_out(mb), .mem_wr_data_in(mwi),
        .mem_wr_data_out(mwo), .mem_rd_data_in(mri), .io_data_out(mio)
    );

    sox_spi_peer peer (
        .sel_in(sel_w), .sclk_in(sclk_w), .dout_in(dout_w), .load_in(go),
        .mode_in(cm), .len_in(el), .tx_in(ptx), .din_out(din),
        .rx_out(prx)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic results;
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tmo;
        n_fail++;
        $display("MISMATCH wait expected done seen timeout");
        results();
    endtask

    task automatic nc(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic [5:0] explen(input logic [5:0] l);
        return (l == 6'h00) ? 6'h01 : ((l > 6'h20) ? 6'h20 : l);
    endfunction

    function automatic int exph(input logic [15:0] p);
        int h;
        h = (int'(p) * CLK_FREQ_MHZ + 1) / 2;
        return (h < H) ? H : h;
    endfunction

    function automatic logic [31:0] lmask(input logic [5:0] l);
        return (l == 6'h20) ? 32'hFFFFFFFF : ((32'h1 << l) - 32'h1);
    endfunction

    task automatic swrite(input logic [7:0] v, input logic m);
        sd = v;
        meas = m;
        swr = 1'b1;
        nc(1);
        swr = 1'b0;
        meas = 1'b0;
    endtask

    task automatic cfg(input logic [5:0] l, input logic [1:0] m,
                       input logic r);
        cl = l;
        cm = m;
        rt = r;
        cwr = 1'b1;
        nc(1);
        cwr = 1'b0;
        el = explen(l);
        nc(2);
    endtask

    task automatic pop;
        int i;
        i = 0;
        while (rv !== 1'b1 && i < 9)
        begin
            nc(1);
            i++;
        end
        if (i == 9)
            tmo();
        chk("rdata", rd, q.pop_front());
        rr = 1'b1;
        nc(1);
        rr = 1'b0;
        nc(1);
    endtask

    task automatic xfer(input logic r, input logic e);
        int   i;
        int   nt;
        int   gap;
        int   mg;
        logic s0;
        i = 0;
        while (xrdy !== 1'b1 && i < 99)
        begin
            nc(1);
            i++;
        end
        if (i == 99)
            tmo();
        pin = 8'($urandom);
        ptx = $urandom;
        xd = $urandom;
        xrd = r;
        xend = e;
        xs = 1'b1;
        go = 1'b1;
        nc(1);
        xs = 1'b0;
        go = 1'b0;
        s0 = sclk_w;
        nt = 0;
        gap = 0;
        mg = 999;
        while (busy === 1'b1 && i < 999)
        begin
            nc(1);
            i++;
            gap++;
            if (sclk_w !== s0)
            begin
                nt++;
                mg = (gap < mg) ? gap : mg;
                gap = 0;
                s0 = sclk_w;
            end
        end
        if (i >= 999)
            tmo();
        nc(2);
        chk("edges", nt, 2 * el);
        chk("gap", mg, exph(per));
        chk("sel_end", sel_w, e);
        chk("idle", sclk_w, cm[0]);
        chk("tx", prx, xd & lmask(el));
        chk("pat", rt ? po[4:0] : po, rt ? pin[4:0] : pin);
        chk("sta", rt ? sp : sp[4:0], rt ? sv : sv[4:0]);
        if (r)
            q.push_back(ptx & lmask(el));
        if (q.size() == 2)
        begin
            chk("full", xrdy, 32'h0);
            pop();
            pop();
        end
    endtask

    initial
    begin
        n_fail = 0;
        num_checks = 0;
        {rstn, meas, swr, cwr, rt, xs, xrd, xend, rr, mwr, go} = '0;
        opm = OPMODE_LOW_SPEED;
        {sd, sv, cl, cm, el, xd, ptx, md, mwi, mri, per} = '0;
        void'($urandom(32'h757C));
        pin = 8'($urandom);
        nc(5);
        chk("rst", {sp, po}, 32'h0);
        chk("rst_mask", mb, 32'h0);
        chk("rst_st", {xrdy, busy, rv}, 32'h0);
        rstn = 1'b1;
        nc(1);
        for (int k = 0; k < 4; k++)
        begin
            sv = 8'($urandom);
            swrite(sv, 1'b0);
            chk("sback", sb, sv);
            nc(1);
            chk("spins", sp, sv);
            swrite(~sv, 1'b1);
            nc(1);
            chk("smeas", {sb, sp}, {sv, sv});
        end
        for (int k = 0; k < 6; k++)
        begin
            opm = {2'h0, k[0]};
            md = (k == 5) ? 24'h0 : 24'($urandom);
            mwi = 24'($urandom);
            mri = 24'($urandom);
            mwr = 1'b1;
            nc(1);
            mwr = 1'b0;
            nc(1);
            chk("mask", mb, md);
            chk("mwr", mwo, mwi ^ md);
            chk("mrd", mio, mri ^ md);
        end
        opm = OPMODE_LOW_SPEED;
        for (int mo = 0; mo < 4; mo++)
            for (int li = 0; li < 5; li++)
            begin
                per = (mo == 3 && li == 1) ? 16'h0001 : 16'h0000;
                cfg(6'(lens[li]), 2'(mo), 1'($urandom));
                chk("cfgsel", sel_w, 32'h1);
                chk("cfgclk", sclk_w, cm[0]);
                xfer(1'($urandom), 1'b0);
                xfer(1'($urandom), 1'b1);
                xfer(1'($urandom), 1'b0);
            end
        for (int k = 1; k < 3; k++)
        begin
            opm = 3'(k);
            cfg(6'h08, 2'h1, 1'b0);
            xs = 1'b1;
            nc(1);
            xs = 1'b0;
            nc(1);
            chk("hs", {xrdy, busy}, 32'h0);
            chk("hs_pins", sp, sv);
        end
        while (q.size() > 0)
            pop();
        chk("empty", rv, 32'h0);
        results();
    end
endmodule
